// [hdl/crfm_regfile.sv]
/*
 * Working register file with one-cycle ALU, pointer pairs, data-space
 * decoder, table read and program counter.
 * Assumes the execution core on the same clock presents one request at
 * a time and waits while busy; I/O, SRAM and USB answer combinationally.
 */
`timescale 1ns/1ps
`default_nettype none
module crfm_regfile
    import crfm_pkg::*;
(
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Register operation
    input wire crfm_alu_s alu_i,
    // Data-space access
    input wire crfm_dreq_s dreq_i,
    // Table read
    input wire logic tbl_req_i,
    input wire logic [4:0] tbl_dst_i,
    input wire logic [15:0] prog_data_i,
    // Program counter control
    input wire logic pc_load_i,
    input wire logic [13:0] pc_value_i,
    input wire logic pc_step_i,
    // Register peek
    input wire logic [4:0] peek_idx_i,
    // Region read data
    input wire crfm_byte_t io_rdata_i,
    input wire crfm_byte_t sram_rdata_i,
    input wire crfm_byte_t usb_rdata_i,
    // Region bus
    output var crfm_bus_s bus_o,
    output logic io_sel_o,
    output logic sram_sel_o,
    output logic usb_sel_o,
    // Program memory
    output logic [13:0] prog_addr_o,
    output logic prog_rd_o,
    output logic [13:0] program_counter_o,
    // Status
    output var crfm_byte_t load_data_o,
    output logic load_done_o,
    output logic busy_o,
    output logic err_o,
    output logic carry_o,
    output logic zero_o,
    output var crfm_byte_t peek_data_o
);

    // ==================================================================
    // Declarations
    crfm_byte_t rf [RF_DEPTH];
    crfm_state_e st;
    crfm_state_e next_st;
    logic alu_go;
    logic dat_go;
    logic tbl_go;
    logic [4:0] alu_dst;
    crfm_byte_t op_a;
    crfm_byte_t op_b;
    logic [8:0] sum;
    logic alu_wr;
    logic alu_bad;
    logic [4:0] plo;
    logic [4:0] phi;
    crfm_addr_t ptr_val;
    crfm_addr_t ea;
    crfm_addr_t ptr_next;
    logic ptr_wr;
    logic agen_bad;
    logic dat_ok;
    crfm_region_e dreg;
    crfm_region_e ld_reg;
    logic [4:0] ld_dst;
    crfm_byte_t rf_cap;
    crfm_byte_t ld_val;
    crfm_byte_t tbl_val;
    crfm_addr_t zptr;
    logic tbl_hi;
    logic tbl_oob;

    // Only one request per idle cycle; ALU first, then data, then table
    assign alu_go = ce_i && st == ST_IDLE && alu_i.valid;
    assign dat_go = ce_i && st == ST_IDLE && !alu_i.valid && dreq_i.valid;
    assign tbl_go = ce_i && st == ST_IDLE && !alu_i.valid && !dreq_i.valid && tbl_req_i;
    assign dat_ok = dat_go && !agen_bad;

    // ==================================================================
    // ALU operand fetch and result
    always_comb begin
        // RQ3 immediates map to upper half
        alu_dst = alu_i.imm ? {1'b1, alu_i.dst[3:0]} : alu_i.dst;
        // RQ4 full file otherwise
        op_a = rf[alu_dst];
        op_b = alu_i.imm ? alu_i.k : rf[alu_i.src];
        case (alu_i.op)
            OP_ADD: sum = {1'b0, op_a} + {1'b0, op_b};
            OP_ADC: sum = {1'b0, op_a} + {1'b0, op_b} + {8'h00, carry_o};
            OP_SUB: sum = {1'b0, op_a} - {1'b0, op_b};
            OP_CP: sum = {1'b0, op_a} - {1'b0, op_b};
            OP_SBC: sum = {1'b0, op_a} - {1'b0, op_b} - {8'h00, carry_o};
            OP_AND: sum = {carry_o, op_a & op_b};
            OP_OR: sum = {carry_o, op_a | op_b};
            OP_EOR: sum = {carry_o, op_a ^ op_b};
            OP_MOV: sum = {carry_o, op_b};
            OP_INC: sum = {carry_o, op_a + 8'h01};
            OP_DEC: sum = {carry_o, op_a - 8'h01};
            OP_COM: sum = {1'b1, ~op_a};
            default: sum = {carry_o, op_a};
        endcase
        alu_wr = alu_i.op != OP_CP;
        // RQ3 only six forms take a constant
        alu_bad = alu_i.imm
            && !(alu_i.op inside {OP_SUB, OP_SBC, OP_CP, OP_AND, OP_OR, OP_MOV});
    end

    // ==================================================================
    // Pointer selection and address generation
    always_comb begin
        // RQ5 even low byte, odd high byte
        case (dreq_i.psel)
            PS_TWO: begin
                plo = PTR_TWO_LOW;
                phi = PTR_TWO_HIGH;
            end
            PS_THREE: begin
                plo = PTR_THREE_LOW;
                phi = PTR_THREE_HIGH;
            end
            default: begin
                plo = PTR_ONE_LOW;
                phi = PTR_ONE_HIGH;
            end
        endcase
        ptr_val = {rf[phi], rf[plo]};
    end

    // RQ7 displacement and stepping
    crfm_agen u_agen (
        .mode_i(dreq_i.mode),
        .psel_i(dreq_i.psel),
        .disp_i(dreq_i.disp),
        .direct_i(dreq_i.addr),
        .ptr_i(ptr_val),
        .ea_o(ea),
        .ptr_next_o(ptr_next),
        .ptr_wr_o(ptr_wr),
        .bad_o(agen_bad)
    );

    // RQ11 RQ19 RQ17 region decode
    assign dreg = crfm_region(ea);
    // RQ18 pointer three for table reads
    assign zptr = {rf[PTR_THREE_HIGH], rf[PTR_THREE_LOW]};

    // ==================================================================
    // Sequencing
    always_comb begin
        next_st = st;
        case (st)
            ST_IDLE: begin
                if (dat_ok && !dreq_i.we) begin
                    next_st = ST_LOAD;
                end else if (tbl_go) begin
                    next_st = ST_TABLE;
                end
            end
            default: begin
                next_st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st <= ST_IDLE;
            busy_o <= 1'b0;
        end else if (ce_i) begin
            st <= next_st;
            busy_o <= next_st != ST_IDLE;
        end
    end

    // ==================================================================
    // Load data selection
    always_comb begin
        // RQ20 unmapped reads give zero
        case (ld_reg)
            RG_RF: ld_val = rf_cap;
            RG_IO: ld_val = io_rdata_i;
            RG_SRAM: ld_val = sram_rdata_i;
            RG_USB: ld_val = usb_rdata_i;
            default: ld_val = 8'h00;
        endcase
        // Words past the last program word read as zero
        if (tbl_oob) begin
            tbl_val = 8'h00;
        end else begin
            tbl_val = tbl_hi ? prog_data_i[15:8] : prog_data_i[7:0];
        end
    end

    // ==================================================================
    // Register file writes
    // Later statements win: pointer write-back beats a store to itself
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < RF_DEPTH; i++) begin
                rf[i] <= RF_RESET;
            end
        end else if (ce_i) begin
            // RQ2 RQ8 single-cycle write-back
            if (alu_go && alu_wr && !alu_bad) begin
                rf[alu_dst] <= sum[7:0];
            end
            // RQ1 RQ6 store into register space
            if (dat_ok && dreq_i.we && dreg == RG_RF) begin
                rf[ea[4:0]] <= dreq_i.wdata;
            end
            // RQ15 pointer write-back
            if (dat_ok && ptr_wr) begin
                rf[plo] <= ptr_next[7:0];
                rf[phi] <= ptr_next[15:8];
            end
            if (st == ST_LOAD) begin
                rf[ld_dst] <= ld_val;
            end
            if (st == ST_TABLE) begin
                rf[ld_dst] <= tbl_val;
            end
        end
    end

    // ==================================================================
    // Flags and errors
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            carry_o <= 1'b0;
            zero_o <= 1'b0;
            err_o <= 1'b0;
        end else if (ce_i) begin
            if (alu_go && !alu_bad) begin
                carry_o <= sum[8];
                zero_o <= sum[7:0] == 8'h00;
            end
            err_o <= (alu_go && alu_bad) || (dat_go && agen_bad);
        end
    end

    // ==================================================================
    // Region bus and access capture
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_o <= '0;
            io_sel_o <= 1'b0;
            sram_sel_o <= 1'b0;
            usb_sel_o <= 1'b0;
            ld_reg <= RG_NONE;
            ld_dst <= 5'h00;
            rf_cap <= RF_RESET;
            prog_addr_o <= PC_RESET;
            prog_rd_o <= 1'b0;
            tbl_hi <= 1'b0;
            tbl_oob <= 1'b0;
        end else if (ce_i) begin
            io_sel_o <= 1'b0;
            sram_sel_o <= 1'b0;
            usb_sel_o <= 1'b0;
            prog_rd_o <= 1'b0;
            // RQ16 every mode feeds one decoder
            if (dat_ok) begin
                bus_o.we <= dreq_i.we;
                bus_o.addr <= ea;
                bus_o.wdata <= dreq_i.wdata;
                io_sel_o <= dreg == RG_IO;
                sram_sel_o <= dreg == RG_SRAM;
                usb_sel_o <= dreg == RG_USB;
                ld_reg <= dreg;
                ld_dst <= dreq_i.dst;
                rf_cap <= rf[ea[4:0]];
            end
            // RQ10 any word of program memory
            if (tbl_go) begin
                prog_addr_o <= zptr[14:1];
                prog_rd_o <= zptr[15:1] <= {1'b0, PC_LAST};
                tbl_oob <= zptr[15:1] > {1'b0, PC_LAST};
                tbl_hi <= zptr[0];
                ld_dst <= tbl_dst_i;
            end
        end
    end

    // ==================================================================
    // Load result, program counter, peek
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            load_done_o <= 1'b0;
            load_data_o <= 8'h00;
            peek_data_o <= RF_RESET;
        end else if (ce_i) begin
            load_done_o <= st == ST_LOAD || st == ST_TABLE;
            if (st == ST_LOAD) begin
                load_data_o <= ld_val;
            end else if (st == ST_TABLE) begin
                load_data_o <= tbl_val;
            end
            peek_data_o <= rf[peek_idx_i];
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            program_counter_o <= PC_RESET;
        end else if (ce_i) begin
            // RQ9 counter wraps at last word
            if (pc_load_i && pc_value_i <= PC_LAST) begin
                program_counter_o <= pc_value_i;
            end else if (pc_step_i && !pc_load_i) begin
                program_counter_o <= (program_counter_o == PC_LAST)
                    ? PC_RESET : program_counter_o + 14'h0001;
            end
        end
    end

    // ==================================================================
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_read_taken;
        dat_ok && !dreq_i.we;
    endsequence

    // No select in the access cycle, result one cycle later
    sequence s_load_back;
        !io_sel_o && !sram_sel_o && !usb_sel_o ##1 load_done_o;
    endsequence

    chk_imm_upper: assert property ( // RQ3
        alu_go && alu_i.imm && alu_i.op == OP_MOV
        |=> rf[{1'b1, $past(alu_i.dst[3:0])}] == $past(alu_i.k)
    ) else $error("immediate load missed upper register");

    chk_alu_onecycle: assert property ( // RQ8
        alu_go && !alu_i.imm && alu_i.op == OP_ADD && alu_i.dst != alu_i.src
        |=> rf[$past(alu_i.dst)] == $past(op_a) + $past(op_b)
    ) else $error("register add not done in one cycle");

    chk_ptr_postinc: assert property ( // RQ15
        s_read_taken and dreq_i.mode == AM_POSTINC
        |=> {rf[$past(phi)], rf[$past(plo)]} == $past(ptr_val) + 16'h0001
    ) else $error("post-increment pointer not advanced");

    chk_ptr_predec: assert property ( // RQ15
        s_read_taken and dreq_i.mode == AM_PREDEC
        |=> bus_o.addr == $past(ptr_val) - 16'h0001
            && {rf[$past(phi)], rf[$past(plo)]} == bus_o.addr
    ) else $error("pre-decrement address or pointer wrong");

    chk_sram_route: assert property ( // RQ11
        dat_ok && ea > IO_LAST && ea <= SRAM_LAST
        |=> sram_sel_o && !io_sel_o && !usb_sel_o && bus_o.addr == $past(ea)
    ) else $error("SRAM access not routed to SRAM");

    chk_usb_route: assert property ( // RQ17
        dat_ok && ea >= USB_BASE && ea <= USB_LAST
        |=> usb_sel_o && !sram_sel_o
    ) else $error("USB window access misrouted");

    chk_unmapped_zero: assert property ( // RQ20
        (s_read_taken and dreg == RG_NONE)
        |=> s_load_back ##0 (load_data_o == 8'h00)
    ) else $error("unmapped read did not return zero");

    chk_disp_base: assert property ( // RQ14
        dat_go && dreq_i.mode == AM_DISP && dreq_i.psel == PS_ONE
        |=> err_o && !io_sel_o && !sram_sel_o && !usb_sel_o && !busy_o
    ) else $error("pointer one accepted as displacement base");

    chk_rf_space: assert property ( // RQ1
        dat_ok && dreq_i.we && dreg == RG_RF && !ptr_wr
        |=> rf[$past(ea[4:0])] == $past(dreq_i.wdata)
    ) else $error("store to register address lost");

    chk_pc_wrap: assert property ( // RQ9
        ce_i && program_counter_o == PC_LAST && pc_step_i && !pc_load_i
        |=> program_counter_o == PC_RESET
    ) else $error("program counter did not wrap");

endmodule : crfm_regfile
`default_nettype wire

// [hdl/crfm_pkg.sv]
/*
 * Constants, types and decode helpers for the processor register file
 * and data-space map.
 * Assumes one processor clock; all users import the whole package.
 */
// Contract
// RQ1: The 32 working registers also answer at data addresses 0x00 to 0x1F.
// RQ2: Register instructions reach any register directly in one cycle.
// RQ3: Immediate-operand instructions may target only registers 16 to 31.
// RQ4: Non-immediate and single-register operations may use any register.
// RQ5: Registers 26..31 form three 16-bit pointers, low byte in the even one.
// RQ6: Pointers can address any working register through its data address.
// RQ7: Pointers support fixed displacement, auto increment and auto decrement.
// RQ8: A register-to-register ALU operation reads and completes in one cycle.
// RQ9: Program memory is 12K words of 16 bits; program counter is 14 bits.
// RQ10: Table read fetches constants from anywhere in program memory.
// RQ11: First 96 addresses select registers plus I/O, next 1024 select SRAM.
// RQ12: Five modes: direct, indirect, displacement, pre-decrement, post-increment.
// RQ13: Direct addressing reaches the whole data space.
// RQ14: Displacement adds 0..63 to pointer two or three, never pointer one.
// RQ15: Pre-decrement and post-increment write the changed pointer back.
// RQ16: Registers, I/O and SRAM are reachable through every addressing mode.
// RQ17: Addresses 0x1F00 to 0x1FFF route to the USB control window.
// RQ18: Pointer three supplies the byte address for table reads.
// RQ19: The 64 I/O locations answer at data addresses 0x20 to 0x5F.
// RQ20: Unmapped reads return zero; unmapped writes have no effect.
package crfm_pkg;

    // ==================================================================
    // Sizes and reset values
    localparam int unsigned RF_DEPTH = 32;
    typedef logic [7:0] crfm_byte_t;
    typedef logic [15:0] crfm_addr_t;
    localparam crfm_byte_t RF_RESET = 8'h00;
    localparam logic [13:0] PC_RESET = 14'h0000;
    // Last program word, 12,288 words in all
    localparam logic [13:0] PC_LAST = 14'h2FFF;

    // ==================================================================
    // Pointer register indices
    localparam logic [4:0] PTR_ONE_LOW = 5'h1A;
    localparam logic [4:0] PTR_ONE_HIGH = 5'h1B;
    localparam logic [4:0] PTR_TWO_LOW = 5'h1C;
    localparam logic [4:0] PTR_TWO_HIGH = 5'h1D;
    localparam logic [4:0] PTR_THREE_LOW = 5'h1E;
    localparam logic [4:0] PTR_THREE_HIGH = 5'h1F;

    // ==================================================================
    // Data-space map
    localparam crfm_addr_t RF_LAST = 16'h001F;
    localparam crfm_addr_t IO_LAST = 16'h005F;
    localparam crfm_addr_t SRAM_LAST = 16'h045F;
    localparam crfm_addr_t USB_BASE = 16'h1F00;
    localparam crfm_addr_t USB_LAST = 16'h1FFF;

    // ==================================================================
    // Enumerations
    typedef enum logic [2:0] {AM_DIRECT, AM_IND, AM_DISP, AM_PREDEC, AM_POSTINC} crfm_amode_e;
    typedef enum logic [1:0] {PS_ONE, PS_TWO, PS_THREE} crfm_psel_e;
    typedef enum logic [3:0] {
        OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR,
        OP_EOR, OP_MOV, OP_CP, OP_INC, OP_DEC, OP_COM
    } crfm_aluop_e;
    typedef enum logic [2:0] {RG_NONE, RG_RF, RG_IO, RG_SRAM, RG_USB} crfm_region_e;
    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_TABLE} crfm_state_e;

    // ==================================================================
    // Carriers
    typedef struct packed {
        logic valid;
        crfm_aluop_e op;
        logic imm;
        logic [4:0] dst;
        logic [4:0] src;
        crfm_byte_t k;
    } crfm_alu_s;

    typedef struct packed {
        logic valid;
        crfm_amode_e mode;
        crfm_psel_e psel;
        logic [5:0] disp;
        crfm_addr_t addr;
        logic we;
        crfm_byte_t wdata;
        logic [4:0] dst;
    } crfm_dreq_s;

    typedef struct packed {
        logic we;
        crfm_addr_t addr;
        crfm_byte_t wdata;
    } crfm_bus_s;

    // ==================================================================
    // Data-space decode, shared by logic and checks
    function automatic crfm_region_e crfm_region(input crfm_addr_t a);
        if (a <= RF_LAST) begin
            return RG_RF;
        end else if (a <= IO_LAST) begin
            return RG_IO;
        end else if (a <= SRAM_LAST) begin
            return RG_SRAM;
        end else if (a >= USB_BASE && a <= USB_LAST) begin
            return RG_USB;
        end else begin
            return RG_NONE;
        end
    endfunction : crfm_region

endpackage : crfm_pkg

// [hdl/crfm_agen.sv]
/*
 * Effective-address generator for data-space accesses.
 * Assumes the caller supplies the selected pointer value and commits
 * the write-back only when the access is taken.
 */
`timescale 1ns/1ps
`default_nettype none
module crfm_agen
    import crfm_pkg::*;
(
    // Request
    input wire crfm_amode_e mode_i,
    input wire crfm_psel_e psel_i,
    input wire logic [5:0] disp_i,
    input wire crfm_addr_t direct_i,
    input wire crfm_addr_t ptr_i,
    // Result
    output var crfm_addr_t ea_o,
    output var crfm_addr_t ptr_next_o,
    output logic ptr_wr_o,
    output logic bad_o
);

    // ==================================================================
    // Address arithmetic
    always_comb begin
        ea_o = ptr_i;
        ptr_next_o = ptr_i;
        ptr_wr_o = 1'b0;
        bad_o = (mode_i != AM_DIRECT)
            && !(psel_i inside {PS_ONE, PS_TWO, PS_THREE});
        // RQ12 five addressing modes
        case (mode_i)
            // RQ13 direct reaches all
            AM_DIRECT: begin
                ea_o = direct_i;
            end
            AM_IND: begin
                ea_o = ptr_i;
            end
            // RQ14 displacement on two or three
            AM_DISP: begin
                ea_o = ptr_i + {10'h000, disp_i};
                if (psel_i == PS_ONE) begin
                    bad_o = 1'b1;
                end
            end
            // RQ15 decrement before access
            AM_PREDEC: begin
                ea_o = ptr_i - 16'h0001;
                ptr_next_o = ptr_i - 16'h0001;
                ptr_wr_o = 1'b1;
            end
            // RQ15 increment after access
            AM_POSTINC: begin
                ptr_next_o = ptr_i + 16'h0001;
                ptr_wr_o = 1'b1;
            end
            default: begin
                bad_o = 1'b1;
            end
        endcase
    end

endmodule : crfm_agen
`default_nettype wire

// [verif/crfm_mem_model.sv]
/*
 * Far-side model: I/O, SRAM and USB window read data, program words.
 * Assumes the block samples read data in the cycle its select is high.
 */
`timescale 1ns/1ps
`default_nettype none
module crfm_mem_model
    import crfm_pkg::*;
(
    // Region side
    input wire crfm_bus_s bus_i,
    input wire logic io_sel_i,
    input wire logic sram_sel_i,
    input wire logic usb_sel_i,
    // Program side
    input wire logic [13:0] prog_addr_i,
    input wire logic prog_rd_i,
    // Answers
    output var crfm_byte_t io_rdata_o,
    output var crfm_byte_t sram_rdata_o,
    output var crfm_byte_t usb_rdata_o,
    output var logic [15:0] prog_data_o
);
    // Unselected: inverse value, so a late capture shows up
    assign io_rdata_o = {8{~io_sel_i}} ^ bus_i.addr[7:0] ^ 8'hc3;
    assign sram_rdata_o = {8{~sram_sel_i}} ^ bus_i.addr[7:0] ^ 8'h3c;
    assign usb_rdata_o = {8{~usb_sel_i}} ^ bus_i.addr[7:0] ^ 8'h99;
    assign prog_data_o = {16{~prog_rd_i}} ^ {2'b00, prog_addr_i} ^ 16'h5a00;
endmodule : crfm_mem_model
`default_nettype wire

// [verif/tb_cpu_regfile_data_space_map.sv]
/*
 * Self-checking bench for the register file and data-space map.
 * Assumes crfm_mem_model answers the region and program buses.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_regfile_data_space_map
    import crfm_pkg::*;
;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    crfm_alu_s alu = '0;
    crfm_dreq_s dq = '0;
    logic tbl_req = 1'b0;
    logic pc_load = 1'b0;
    logic pc_step = 1'b0;
    logic [13:0] pc_value = 14'h0000;
    logic [4:0] peek_idx = 5'h00;
    crfm_byte_t io_rd, sram_rd, usb_rd, load_data, peek_data, s_data;
    crfm_bus_s bus;
    logic [15:0] prog_data;
    logic [13:0] prog_addr, pc;
    logic io_sel, sram_sel, usb_sel, prog_rd, load_done, busy, err, carry, zero, s_err;
    logic [3:0] s_sel;
    crfm_addr_t s_addr;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #20 clock = ~clock;

    crfm_regfile dut (.clock_i(clock), .reset_n_i(reset_n), .ce_i(ce), .alu_i(alu),
        .dreq_i(dq), .tbl_req_i(tbl_req), .tbl_dst_i(5'h04), .prog_data_i(prog_data),
        .pc_load_i(pc_load), .pc_value_i(pc_value), .pc_step_i(pc_step),
        .peek_idx_i(peek_idx), .io_rdata_i(io_rd), .sram_rdata_i(sram_rd),
        .usb_rdata_i(usb_rd), .bus_o(bus), .io_sel_o(io_sel), .sram_sel_o(sram_sel),
        .usb_sel_o(usb_sel), .prog_addr_o(prog_addr), .prog_rd_o(prog_rd),
        .program_counter_o(pc), .load_data_o(load_data), .load_done_o(load_done),
        .busy_o(busy), .err_o(err), .carry_o(carry), .zero_o(zero),
        .peek_data_o(peek_data));

    crfm_mem_model mem (.bus_i(bus), .io_sel_i(io_sel), .sram_sel_i(sram_sel),
        .usb_sel_i(usb_sel), .prog_addr_i(prog_addr), .prog_rd_i(prog_rd),
        .io_rdata_o(io_rd), .sram_rdata_o(sram_rd), .usb_rdata_o(usb_rd),
        .prog_data_o(prog_data));

    // ==========
    // Shared tasks
    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic alu_op(input crfm_aluop_e op, input logic imm, input logic [4:0] d,
                          input logic [4:0] s, input crfm_byte_t k);
        @(negedge clock);
        alu = '{1'b1, op, imm, d, s, k};
        @(negedge clock);
        alu.valid = 1'b0;
        s_err = err;
    endtask : alu_op

    // Load target is always register 2
    task automatic dacc(input crfm_amode_e m, input crfm_psel_e p, input logic [5:0] d,
                        input crfm_addr_t a, input logic we, input crfm_byte_t wd);
        @(negedge clock);
        dq = '{1'b1, m, p, d, a, we, wd, 5'h02};
        @(negedge clock);
        dq.valid = 1'b0;
        s_sel = {busy, io_sel, sram_sel, usb_sel};
        s_addr = bus.addr;
        s_err = err;
        @(negedge clock);
        s_data = load_done ? load_data : 8'hee;
    endtask : dacc

    task automatic peek(input logic [4:0] i, input crfm_byte_t exp);
        @(negedge clock);
        peek_idx = i;
        @(negedge clock);
        chk(peek_data, exp);
    endtask : peek

    task automatic ptr(input logic [4:0] r, input logic [15:0] v);
        dacc(AM_DIRECT, PS_ONE, 6'h00, {11'h000, r}, 1'b1, v[7:0]);
        dacc(AM_DIRECT, PS_ONE, 6'h00, {11'h000, r + 5'h01}, 1'b1, v[15:8]);
    endtask : ptr

    task automatic tbl(input logic rd, input logic [13:0] a, input crfm_byte_t exp);
        @(negedge clock);
        tbl_req = 1'b1;
        @(negedge clock);
        tbl_req = 1'b0;
        chk({prog_rd, busy, prog_addr}, {rd, 1'b1, a});
        @(negedge clock);
        chk({load_done, load_data}, {1'b1, exp});
    endtask : tbl

    // ==========
    // Scenarios
    task automatic t_alu();
        crfm_aluop_e op;
        peek(5'h1f, 8'h00);
        alu_op(OP_MOV, 1'b1, 5'h00, 5'h00, 8'h12);
        alu_op(OP_MOV, 1'b1, 5'h11, 5'h00, 8'hf0);
        alu_op(OP_ADD, 1'b0, 5'h11, 5'h10, 8'h00);
        chk({carry, zero}, 2'b10);
        peek(5'h11, 8'h02);
        alu_op(OP_MOV, 1'b0, 5'h01, 5'h11, 8'h00);
        peek(5'h01, 8'h02);
        for (int i = 0; i < 12; i++) begin
            op = crfm_aluop_e'(i);
            alu_op(op, 1'b1, 5'h07, 5'h00, 8'h0f);
            chk(s_err, !(op inside {OP_SUB, OP_SBC, OP_CP, OP_AND, OP_OR, OP_MOV}));
        end
        $display("alu test done");
    endtask : t_alu

    task automatic t_data();
        ptr(5'h1a, 16'h0060);
        chk(s_sel, 4'h0);
        chk({bus.we, bus.addr, bus.wdata}, {1'b1, 16'h001b, 8'h00});
        dacc(AM_POSTINC, PS_ONE, 6'h00, 16'h0000, 1'b0, 8'h00);
        chk({s_sel, s_addr}, {4'ha, 16'h0060});
        chk(s_data, 8'h5c);
        peek(5'h1a, 8'h61);
        ptr(5'h1c, 16'h0060);
        dacc(AM_PREDEC, PS_TWO, 6'h00, 16'h0000, 1'b0, 8'h00);
        chk({s_sel, s_addr, s_data}, {4'hc, 16'h005f, 8'h9c});
        peek(5'h1c, 8'h5f);
        dacc(AM_DISP, PS_TWO, 6'h3f, 16'h0000, 1'b0, 8'h00);
        chk({s_sel, s_addr}, {4'ha, 16'h009e});
        ptr(5'h1e, 16'h1f00);
        dacc(AM_DISP, PS_THREE, 6'h3f, 16'h0000, 1'b0, 8'h00);
        chk({s_sel, s_addr, s_data}, {4'h9, 16'h1f3f, 8'ha6});
        dacc(AM_DISP, PS_ONE, 6'h01, 16'h0000, 1'b0, 8'h00);
        chk({s_err, s_sel}, 5'h10);
        ptr(5'h1a, 16'h0011);
        dacc(AM_IND, PS_ONE, 6'h00, 16'h0000, 1'b0, 8'h00);
        chk({s_sel, s_data}, {4'h8, 8'h02});
        dacc(AM_DIRECT, PS_ONE, 6'h00, 16'h0460, 1'b0, 8'h00);
        chk({s_sel, s_data}, {4'h8, 8'h00});
        $display("data test done");
    endtask : t_data

    task automatic t_table();
        ptr(5'h1e, 16'h0003);
        tbl(1'b1, 14'h0001, 8'h5a);
        peek(5'h04, 8'h5a);
        ptr(5'h1e, 16'h6000);
        tbl(1'b0, 14'h3000, 8'h00);
        $display("table test done");
    endtask : t_table

    task automatic t_pc();
        @(negedge clock);
        pc_load = 1'b1;
        pc_value = 14'h2fff;
        @(negedge clock);
        pc_load = 1'b0;
        pc_step = 1'b1;
        chk(pc, 14'h2fff);
        @(negedge clock);
        pc_step = 1'b0;
        chk(pc, 14'h0000);
        $display("pc test done");
    endtask : t_pc

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        repeat (16) @(posedge clock);
        @(negedge clock);
        reset_n = 1'b1;
        t_alu();
        t_data();
        t_table();
        t_pc();
        summarize();
    end
endmodule : tb_cpu_regfile_data_space_map
`default_nettype wire
